// File: design/pec_pkg.sv
// Package of constants for the performance event counter unit.
package pec_pkg;
  // CSR numbers of the standard machine performance monitor.
  localparam logic [11:0] CSR_CYCLE_LO = 12'hb00;
  localparam logic [11:0] CSR_INSTRET_LO = 12'hb02;
  localparam logic [11:0] CSR_HPM_LO_FIRST = 12'hb03;
  localparam logic [11:0] CSR_HPM_LO_LAST = 12'hb1f;
  localparam logic [11:0] CSR_CYCLE_HI = 12'hb80;
  localparam logic [11:0] CSR_INSTRET_HI = 12'hb82;
  localparam logic [11:0] CSR_HPM_HI_FIRST = 12'hb83;
  localparam logic [11:0] CSR_HPM_HI_LAST = 12'hb9f;
  localparam logic [11:0] CSR_SEL_FIRST = 12'h323;
  localparam logic [11:0] CSR_SEL_LAST = 12'h33f;
  // Group count gate register, in the non-standard read/write space.
  localparam logic [11:0] CSR_GROUP_GATE = 12'h7f0;
  // Group gate field and reset value.
  localparam int GATE_EN_BIT = 0;
  localparam logic GATE_EN_RESET = 1'b1;
  // Event codes.
  localparam int EVT_W = 6;
  localparam logic [5:0] EVT_NONE = 6'h00;
  localparam logic [5:0] EVT_CLK_ACTIVE = 6'h01;
  localparam logic [5:0] EVT_IC_HIT = 6'h02;
  localparam logic [5:0] EVT_IC_MISS = 6'h03;
  localparam logic [5:0] EVT_CMT_ALL = 6'h04;
  localparam logic [5:0] EVT_CMT_16 = 6'h05;
  localparam logic [5:0] EVT_CMT_32 = 6'h06;
  localparam logic [5:0] EVT_ALIGNED = 6'h07;
  localparam logic [5:0] EVT_DECODED = 6'h08;
  localparam logic [5:0] EVT_MUL = 6'h09;
  localparam logic [5:0] EVT_DIV = 6'h0a;
  localparam logic [5:0] EVT_LOAD = 6'h0b;
  localparam logic [5:0] EVT_STORE = 6'h0c;
  localparam logic [5:0] EVT_MIS_LOAD = 6'h0d;
  localparam logic [5:0] EVT_MIS_STORE = 6'h0e;
  localparam logic [5:0] EVT_CSR_RD = 6'h10;
  localparam logic [5:0] EVT_CSR_RMW = 6'h11;
  localparam logic [5:0] EVT_MAX = 6'h11;
  localparam int EVT_NUM = 18;
  localparam logic [5:0] SEL_RESET = 6'h00;
  localparam logic [63:0] CNT_RESET = 64'h0;

  // Clamp a written selector value to the highest supported event.
  function automatic logic [5:0] pec_sel_legal(input logic [31:0] wv);
    logic [5:0] r;
    r = (wv > {26'h0, EVT_MAX}) ? EVT_MAX : wv[5:0];
    return r;
  endfunction : pec_sel_legal
endpackage : pec_pkg

// File: design/pec_event_mux.sv
// Picks the per-cycle increment of one counter from the event vector.
`timescale 1ns/1ps
module pec_event_mux (
  // Selection
  input wire logic [5:0] sel,
  // Packed two-bit increments, one slot per event code
  input wire logic [2*pec_pkg::EVT_NUM-1:0] evt_vec,
  // Result
  output logic [1:0] inc
);
  always_comb
  begin
    inc = 2'h0;
    if (sel != pec_pkg::EVT_NONE && sel <= pec_pkg::EVT_MAX)
    begin
      inc = evt_vec[2*sel +: 2];
    end
  end
endmodule : pec_event_mux

// File: design/pec_unit.sv
// Performance event counter unit with CSR access.
`timescale 1ns/1ps
module pec_unit #(
  parameter int NUM_CNT = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // CSR access
  input wire logic csr_rd_en,
  input wire logic csr_wr_en,
  input wire logic [11:0] csr_addr,
  input wire logic [31:0] csr_wdata,
  output logic [31:0] csr_rdata,
  output logic csr_rvalid,
  // Core state
  input wire logic power_halt_state,
  input wire logic debug_halt_state,
  input wire logic dbg_stopcount,
  // Event strobes
  input wire logic ic_hit,
  input wire logic ic_miss,
  input wire logic [1:0] cmt_16_cnt,
  input wire logic [1:0] cmt_32_cnt,
  input wire logic [1:0] aligned_cnt,
  input wire logic [1:0] decoded_cnt,
  input wire logic cmt_mul,
  input wire logic cmt_div,
  input wire logic cmt_load,
  input wire logic cmt_store,
  input wire logic mis_load,
  input wire logic mis_store,
  input wire logic cmt_csr_rd,
  input wire logic cmt_csr_rmw,
  // State views
  output logic group_en
);
  if (NUM_CNT != 4)
  begin : g_bad_count
    $error("pec_unit serves exactly four event counters");
  end

  logic gate_q;
  logic [63:0] cycle_q;
  logic [63:0] instret_q;
  logic [63:0] hpm_q [NUM_CNT];
  logic [5:0] sel_q [NUM_CNT];
  logic [1:0] inc [NUM_CNT];
  logic [31:0] rdata_d;
  logic count_ok;
  logic [1:0] cmt_all;
  logic [2*pec_pkg::EVT_NUM-1:0] evt_vec;

  // Returns the counter slot for an address in a range, or NUM_CNT.
  function automatic int slot_of(input logic [11:0] a,
                                 input logic [11:0] first);
    int r;
    r = NUM_CNT;
    if (a >= first && a < first + 12'(NUM_CNT))
    begin
      r = int'(a - first);
    end
    return r;
  endfunction : slot_of

  // pause does not gate.
  // Every event, cycle and instret too, passes through this one gate.
  assign count_ok = !power_halt_state &&
                    !(debug_halt_state && dbg_stopcount);

  // The two size counts never exceed two together in one cycle.
  assign cmt_all = 2'(cmt_16_cnt + cmt_32_cnt);

  always_comb
  begin
    evt_vec = '0;
    evt_vec[2*pec_pkg::EVT_CLK_ACTIVE +: 2] = 2'h1;
    evt_vec[2*pec_pkg::EVT_IC_HIT +: 2] = {1'b0, ic_hit};
    evt_vec[2*pec_pkg::EVT_IC_MISS +: 2] = {1'b0, ic_miss};
    evt_vec[2*pec_pkg::EVT_CMT_ALL +: 2] = cmt_all;
    evt_vec[2*pec_pkg::EVT_CMT_16 +: 2] = cmt_16_cnt;
    evt_vec[2*pec_pkg::EVT_CMT_32 +: 2] = cmt_32_cnt;
    evt_vec[2*pec_pkg::EVT_ALIGNED +: 2] = aligned_cnt;
    evt_vec[2*pec_pkg::EVT_DECODED +: 2] = decoded_cnt;
    evt_vec[2*pec_pkg::EVT_MUL +: 2] = {1'b0, cmt_mul};
    evt_vec[2*pec_pkg::EVT_DIV +: 2] = {1'b0, cmt_div};
    evt_vec[2*pec_pkg::EVT_LOAD +: 2] = {1'b0, cmt_load};
    evt_vec[2*pec_pkg::EVT_STORE +: 2] = {1'b0, cmt_store};
    evt_vec[2*pec_pkg::EVT_MIS_LOAD +: 2] = {1'b0, mis_load};
    evt_vec[2*pec_pkg::EVT_MIS_STORE +: 2] = {1'b0, mis_store};
    evt_vec[2*pec_pkg::EVT_CSR_RD +: 2] = {1'b0, cmt_csr_rd};
    evt_vec[2*pec_pkg::EVT_CSR_RMW +: 2] = {1'b0, cmt_csr_rmw};
  end

  for (genvar g = 0; g < NUM_CNT; g++)
  begin : g_mux
    pec_event_mux u_mux (
      .sel(sel_q[g]),
      .evt_vec(evt_vec),
      .inc(inc[g])
    );
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      gate_q <= pec_pkg::GATE_EN_RESET;
      group_en <= pec_pkg::GATE_EN_RESET;
    end
    else if (csr_wr_en && csr_addr == pec_pkg::CSR_GROUP_GATE)
    begin
      gate_q <= csr_wdata[pec_pkg::GATE_EN_BIT];
      group_en <= csr_wdata[pec_pkg::GATE_EN_BIT];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cycle_q <= pec_pkg::CNT_RESET;
    end
    else if (csr_wr_en && csr_addr == pec_pkg::CSR_CYCLE_LO)
    begin
      cycle_q[31:0] <= csr_wdata;
    end
    else if (csr_wr_en && csr_addr == pec_pkg::CSR_CYCLE_HI)
    begin
      cycle_q[63:32] <= csr_wdata;
    end
    else if (count_ok)
    begin
      cycle_q <= cycle_q + 64'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      instret_q <= pec_pkg::CNT_RESET;
    end
    else if (csr_wr_en && csr_addr == pec_pkg::CSR_INSTRET_LO)
    begin
      instret_q[31:0] <= csr_wdata;
    end
    else if (csr_wr_en && csr_addr == pec_pkg::CSR_INSTRET_HI)
    begin
      instret_q[63:32] <= csr_wdata;
    end
    else if (count_ok)
    begin
      instret_q <= instret_q + {62'h0, cmt_all};
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_CNT; i++)
      begin
        hpm_q[i] <= pec_pkg::CNT_RESET;
      end
    end
    else
    begin
      for (int i = 0; i < NUM_CNT; i++)
      begin
        if (csr_wr_en &&
            slot_of(csr_addr, pec_pkg::CSR_HPM_LO_FIRST) == i)
        begin
          hpm_q[i][31:0] <= csr_wdata;
        end
        else if (csr_wr_en &&
                 slot_of(csr_addr, pec_pkg::CSR_HPM_HI_FIRST) == i)
        begin
          hpm_q[i][63:32] <= csr_wdata;
        end
        else if (count_ok && gate_q)
        begin
          hpm_q[i] <= hpm_q[i] + {62'h0, inc[i]};
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_CNT; i++)
      begin
        sel_q[i] <= pec_pkg::SEL_RESET;
      end
    end
    else if (csr_wr_en)
    begin
      for (int i = 0; i < NUM_CNT; i++)
      begin
        if (slot_of(csr_addr, pec_pkg::CSR_SEL_FIRST) == i)
        begin
          sel_q[i] <= pec_pkg::pec_sel_legal(csr_wdata);
        end
      end
    end
  end

  // Read data show the value before this cycle's increment.
  always_comb
  begin
    int s;
    s = NUM_CNT;
    rdata_d = 32'h0;
    if (csr_addr == pec_pkg::CSR_GROUP_GATE)
    begin
      rdata_d = {31'h0, gate_q};
    end
    else if (csr_addr == pec_pkg::CSR_CYCLE_LO)
    begin
      rdata_d = cycle_q[31:0];
    end
    else if (csr_addr == pec_pkg::CSR_CYCLE_HI)
    begin
      rdata_d = cycle_q[63:32];
    end
    else if (csr_addr == pec_pkg::CSR_INSTRET_LO)
    begin
      rdata_d = instret_q[31:0];
    end
    else if (csr_addr == pec_pkg::CSR_INSTRET_HI)
    begin
      rdata_d = instret_q[63:32];
    end
    else if (slot_of(csr_addr, pec_pkg::CSR_HPM_LO_FIRST) != NUM_CNT)
    begin
      s = slot_of(csr_addr, pec_pkg::CSR_HPM_LO_FIRST);
      rdata_d = hpm_q[s][31:0];
    end
    else if (slot_of(csr_addr, pec_pkg::CSR_HPM_HI_FIRST) != NUM_CNT)
    begin
      s = slot_of(csr_addr, pec_pkg::CSR_HPM_HI_FIRST);
      rdata_d = hpm_q[s][63:32];
    end
    else if (slot_of(csr_addr, pec_pkg::CSR_SEL_FIRST) != NUM_CNT)
    begin
      s = slot_of(csr_addr, pec_pkg::CSR_SEL_FIRST);
      rdata_d = {26'h0, sel_q[s]};
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      csr_rdata <= 32'h0;
      csr_rvalid <= 1'b0;
    end
    else
    begin
      csr_rdata <= csr_rd_en ? rdata_d : 32'h0;
      csr_rvalid <= csr_rd_en;
    end
  end

  // Checks.
  logic hpm0_wr;
  assign hpm0_wr = csr_wr_en && (csr_addr == pec_pkg::CSR_HPM_LO_FIRST ||
                                 csr_addr == pec_pkg::CSR_HPM_HI_FIRST);

  AST_GATE_RESET: assert property (@(posedge clk)
    rst |=> gate_q && group_en) else $error("gate not one after reset");
  AST_GATE_STOP: assert property (@(posedge clk) disable iff (rst)
    (!gate_q && !hpm0_wr) |=> $stable(hpm_q[0]))
    else $error("event counter moved with gate closed");
  AST_GATE_KEEP: assert property (@(posedge clk) disable iff (rst)
    (csr_wr_en && csr_addr == pec_pkg::CSR_GROUP_GATE && !hpm0_wr)
    |=> hpm_q[0] >= $past(hpm_q[0]) && hpm_q[0] <= $past(hpm_q[0]) + 2)
    else $error("gate write changed a counter");
  AST_GATE_RSVD: assert property (@(posedge clk) disable iff (rst)
    (csr_rd_en && csr_addr == pec_pkg::CSR_GROUP_GATE)
    |=> csr_rdata[31:1] == 31'h0 && csr_rdata[0] == $past(gate_q))
    else $error("gate reserved bits not zero");
  AST_HIGH_ZERO: assert property (@(posedge clk) disable iff (rst)
    (csr_rd_en && csr_addr > pec_pkg::CSR_HPM_LO_FIRST + 12'h3 &&
     csr_addr <= pec_pkg::CSR_HPM_LO_LAST) |=> csr_rdata == 32'h0)
    else $error("unimplemented counter not zero");
  AST_HALT_STOP: assert property (@(posedge clk) disable iff (rst)
    (power_halt_state && !csr_wr_en) [*2] |=> $stable(cycle_q))
    else $error("cycle counter ran in power halt");
  AST_DBG_RUN: assert property (@(posedge clk) disable iff (rst)
    (debug_halt_state && !dbg_stopcount && !power_halt_state &&
     !csr_wr_en) |=> cycle_q == $past(cycle_q) + 64'h1)
    else $error("cycle counter stopped without stopcount");
  AST_SEL_SAT: assert property (@(posedge clk) disable iff (rst)
    (csr_wr_en && csr_addr == pec_pkg::CSR_SEL_FIRST &&
     csr_wdata > 32'h11) |=> sel_q[0] == pec_pkg::EVT_MAX)
    else $error("selector did not saturate");
  AST_WR_WINS: assert property (@(posedge clk) disable iff (rst)
    (csr_wr_en && csr_addr == pec_pkg::CSR_HPM_LO_FIRST)
    |=> hpm_q[0][31:0] == $past(csr_wdata))
    else $error("counter write lost to increment");
  AST_SEL0_IDLE: assert property (@(posedge clk) disable iff (rst)
    (sel_q[0] == 6'h00 && !hpm0_wr) |=> $stable(hpm_q[0]))
    else $error("counter moved with reserved selector");
  COV_GATE_OFF: cover property (@(posedge clk) disable iff (rst)
    gate_q ##1 !gate_q ##[1:4] gate_q);
  COV_HALT: cover property (@(posedge clk) disable iff (rst)
    power_halt_state [*3]);
  COV_DUAL_CMT: cover property (@(posedge clk) disable iff (rst)
    count_ok && gate_q && inc[0] == 2'h2);
endmodule : pec_unit

// File: verification/pec_evt_src.sv
// Model of the core pipeline event sources that feed the counter unit.
`timescale 1ns/1ps
module pec_evt_src (
  // Control
  input wire logic en,
  input wire logic [5:0] code,
  // Event strobes
  output logic ic_hit,
  output logic ic_miss,
  output logic [1:0] cmt_16_cnt,
  output logic [1:0] cmt_32_cnt,
  output logic [1:0] aligned_cnt,
  output logic [1:0] decoded_cnt,
  output logic cmt_mul,
  output logic cmt_div,
  output logic cmt_load,
  output logic cmt_store,
  output logic mis_load,
  output logic mis_store,
  output logic cmt_csr_rd,
  output logic cmt_csr_rmw
);
  // Only the source behind the chosen code fires, so two crossed event
  // wires show up as a wrong count instead of cancelling out.
  // Code 4 commits one of each size, code 5 two short ones and code 6
  // one long one; a core never commits more than two in a cycle.
  assign cmt_16_cnt = (en && code == pec_pkg::EVT_CMT_16) ? 2'h2 :
                      (en && code == pec_pkg::EVT_CMT_ALL) ? 2'h1 : 2'h0;
  assign cmt_32_cnt = (en && (code == pec_pkg::EVT_CMT_32 ||
                      code == pec_pkg::EVT_CMT_ALL)) ? 2'h1 : 2'h0;
  assign aligned_cnt = (en && code == pec_pkg::EVT_ALIGNED) ? 2'h2 : 2'h0;
  assign decoded_cnt = (en && code == pec_pkg::EVT_DECODED) ? 2'h1 : 2'h0;
  assign ic_hit = en && code == pec_pkg::EVT_IC_HIT;
  assign ic_miss = en && code == pec_pkg::EVT_IC_MISS;
  assign cmt_mul = en && code == pec_pkg::EVT_MUL;
  assign cmt_div = en && code == pec_pkg::EVT_DIV;
  assign cmt_load = en && code == pec_pkg::EVT_LOAD;
  assign cmt_store = en && code == pec_pkg::EVT_STORE;
  assign mis_load = en && code == pec_pkg::EVT_MIS_LOAD;
  assign mis_store = en && code == pec_pkg::EVT_MIS_STORE;
  assign cmt_csr_rd = en && code == pec_pkg::EVT_CSR_RD;
  assign cmt_csr_rmw = en && code == pec_pkg::EVT_CSR_RMW;
endmodule : pec_evt_src

// File: verification/pec_unit_bench.sv
// Self-checking bench for the performance event counter unit.
`timescale 1ns/1ps
module pec_unit_bench;
  logic clk, rst, rd, wr, ph, dh, stopc, en, rvalid, group_en;
  logic ih, im, mu, dv, ld, st, ml, ms, cr, cw;
  logic [1:0] c16, c32, al, dc;
  logic [11:0] addr;
  logic [5:0] pick;
  logic [31:0] wdata, rdata, v0, v1;
  int failures, comparisons;
  int rates[18] = '{0, 1, 1, 1, 2, 2, 1, 2, 1, 1, 1, 1, 1, 1, 1, 0, 1, 1};

  pec_unit i_pec_unit (.clk(clk), .rst(rst), .csr_rd_en(rd),
    .csr_wr_en(wr), .csr_addr(addr), .csr_wdata(wdata), .csr_rdata(rdata),
    .csr_rvalid(rvalid), .power_halt_state(ph), .debug_halt_state(dh),
    .dbg_stopcount(stopc), .ic_hit(ih), .ic_miss(im), .cmt_16_cnt(c16),
    .cmt_32_cnt(c32), .aligned_cnt(al), .decoded_cnt(dc), .cmt_mul(mu),
    .cmt_div(dv), .cmt_load(ld), .cmt_store(st), .mis_load(ml),
    .mis_store(ms), .cmt_csr_rd(cr), .cmt_csr_rmw(cw), .group_en(group_en));

  pec_evt_src i_pec_evt_src (.en(en), .ic_hit(ih), .ic_miss(im),
    .cmt_16_cnt(c16), .cmt_32_cnt(c32), .aligned_cnt(al),
    .decoded_cnt(dc), .cmt_mul(mu), .cmt_div(dv), .cmt_load(ld),
    .cmt_store(st), .mis_load(ml), .mis_store(ms), .cmt_csr_rd(cr),
    .cmt_csr_rmw(cw), .code(pick));

  task automatic print_verdict();
    $display("Comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input string what, input logic [31:0] exp, got);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic csr_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : csr_wr

  // The answer stands for one cycle only, so it is taken right then.
  task automatic csr_rd(input logic [11:0] a, output logic [31:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rvalid", 32'h1, {31'h0, rvalid});
    v = rdata;
  endtask : csr_rd

  task automatic burst(input int n, input logic [5:0] c);
    @(posedge clk);
    en <= 1'b1;
    pick <= c;
    repeat (n) @(posedge clk);
    en <= 1'b0;
  endtask : burst

  task automatic set_state(input logic p, d, s);
    @(posedge clk);
    ph <= p;
    dh <= d;
    stopc <= s;
  endtask : set_state

  task automatic cyc_diff(input logic [31:0] exp);
    csr_rd(12'hb00, v0);
    csr_rd(12'hb00, v1);
    chk("cycle step", exp, v1 - v0);
  endtask : cyc_diff

  task automatic t_reset();
    csr_rd(pec_pkg::CSR_GROUP_GATE, v0);
    chk("gate reset", 32'h1, v0);
    chk("group_en reset", 32'h1, {31'h0, group_en});
    @(posedge clk);
    #1;
    chk("rvalid drop", 32'h0, {31'h0, rvalid});
    chk("rdata idle", 32'h0, rdata);
    csr_rd(12'h323, v0);
    chk("sel reset", 32'h0, v0);
    csr_rd(12'hb03, v0);
    chk("cnt reset", 32'h0, v0);
  endtask : t_reset

  task automatic t_gate_bits();
    csr_wr(pec_pkg::CSR_GROUP_GATE, 32'hffffffff);
    csr_rd(pec_pkg::CSR_GROUP_GATE, v0);
    chk("gate high", 32'h1, v0);
    csr_wr(pec_pkg::CSR_GROUP_GATE, 32'hfffffffe);
    csr_rd(pec_pkg::CSR_GROUP_GATE, v0);
    chk("gate low", 32'h0, v0);
    chk("group_en low", 32'h0, {31'h0, group_en});
    csr_wr(pec_pkg::CSR_GROUP_GATE, 32'h1);
  endtask : t_gate_bits

  // Spreads the codes over all four counters; only the selected source
  // fires, so a counter wired to the wrong event reads a wrong count.
  task automatic t_codes(input int first, input int last);
    logic [11:0] k;
    for (int i = first; i <= last; i++)
    begin
      k = 12'(i % 4);
      csr_wr(12'h323 + k, 32'(i));
      csr_rd(12'h323 + k, v0);
      chk("sel back", 32'(i), v0);
      csr_wr(12'hb03 + k, 32'h0);
      burst(5, 6'(i));
      csr_rd(12'hb03 + k, v0);
      chk("evt count", 32'(5 * rates[i]), v0);
    end
  endtask : t_codes

  task automatic t_code1();
    csr_wr(12'h324, 32'h1);
    csr_wr(12'hb04, 32'h40);
    csr_rd(12'hb04, v0);
    chk("clk count", 32'h41, v0);
  endtask : t_code1

  task automatic t_saturate();
    csr_wr(12'h325, 32'h3f);
    csr_rd(12'h325, v0);
    chk("sel sat", 32'h11, v0);
    csr_wr(12'h323, 32'hffffffff);
    csr_rd(12'h323, v0);
    chk("sel sat", 32'h11, v0);
  endtask : t_saturate

  task automatic t_unused();
    logic [11:0] a[6] = '{12'hb07, 12'hb1f, 12'hb87, 12'hb9f, 12'h327,
      12'h33f};
    foreach (a[i])
    begin
      csr_wr(a[i], 32'hffffffff);
      csr_rd(a[i], v0);
      chk("unused", 32'h0, v0);
    end
  endtask : t_unused

  // Upper words of the cycle, instret and one event counter, then a
  // carry out of the cycle counter's lower word.
  task automatic t_hi_words();
    logic [11:0] a[3] = '{12'hb80, 12'hb82, 12'hb84};
    foreach (a[i])
    begin
      csr_wr(a[i], 32'h5a5a0000 + 32'(i));
      csr_rd(a[i], v0);
      chk("high word", 32'h5a5a0000 + 32'(i), v0);
    end
    csr_wr(12'hb00, 32'hfffffffe);
    csr_rd(12'hb80, v0);
    csr_rd(12'hb80, v1);
    chk("carry", 32'h5a5a0001, v1);
  endtask : t_hi_words

  task automatic t_gate_hold();
    csr_wr(12'h323, 32'h4);
    csr_wr(12'hb03, 32'h0);
    burst(3, 6'h4);
    // Software closes the gate before touching counters.
    csr_wr(pec_pkg::CSR_GROUP_GATE, 32'h0);
    burst(4, 6'h4);
    csr_rd(12'hb03, v0);
    chk("gated", 32'h6, v0);
    csr_wr(pec_pkg::CSR_GROUP_GATE, 32'h1);
    csr_rd(12'hb03, v0);
    chk("reopen", 32'h6, v0);
  endtask : t_gate_hold

  task automatic t_halt();
    csr_wr(12'hb03, 32'h0);
    set_state(1'b1, 1'b0, 1'b0);
    burst(3, 6'h4);
    cyc_diff(32'h0);
    csr_rd(12'hb03, v0);
    chk("halt evt", 32'h0, v0);
    set_state(1'b0, 1'b1, 1'b1);
    cyc_diff(32'h0);
    set_state(1'b0, 1'b1, 1'b0);
    cyc_diff(32'h2);
    set_state(1'b0, 1'b0, 1'b0);
    cyc_diff(32'h2);
    csr_rd(12'hb02, v0);
    burst(4, 6'h4);
    csr_rd(12'hb02, v1);
    chk("instret", 32'h8, v1 - v0);
  endtask : t_halt

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    #100000;
    failures++;
    print_verdict();
  end

  initial
  begin
    {rst, rd, wr, ph, dh, stopc, en} = 7'h40;
    pick = 6'h0;
    addr = 12'h0;
    wdata = 32'h0;
    failures = 0;
    comparisons = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_gate_bits();
    t_codes(0, 0);
    t_codes(2, 3);
    t_codes(4, 6);
    t_codes(7, 8);
    t_codes(9, 10);
    t_codes(11, 14);
    t_codes(15, 15);
    t_codes(16, 16);
    t_codes(17, 17);
    t_code1();
    t_saturate();
    t_unused();
    t_hi_words();
    t_gate_hold();
    t_halt();
    print_verdict();
  end
endmodule : pec_unit_bench
